// ### hdl/tcu_pkg.sv
// Package: register map, field layout, modes and timing counts of the timer block
`default_nettype none
package tcu_pkg;
    // Byte addresses of the 8-bit locations, one aligned word each
    localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
    localparam logic [7:0] ADDR_CNT_LO    = 8'h08;
    localparam logic [7:0] ADDR_CNT_HI    = 8'h0C;
    localparam logic [7:0] ADDR_CAP_LO    = 8'h10;
    localparam logic [7:0] ADDR_CAP_HI    = 8'h14;
    localparam logic [7:0] ADDR_FLAGS     = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h1C;
    localparam logic [7:0] ADDR_CMP_CTRL  = 8'h20;
    localparam logic [7:0] ADDR_IRQ_ACK   = 8'h24;
    localparam logic [7:0] ADDR_STATUS    = 8'h28;
    // Field positions
    localparam int CTRL_A_WGM_LSB  = 0;
    localparam int CTRL_B_CS_LSB   = 0;
    localparam int CTRL_B_WGM_LSB  = 3;
    localparam int CTRL_B_EDGE_BIT = 6;
    localparam int CTRL_B_NF_BIT   = 7;
    localparam int FLAG_OVF_BIT    = 0;
    localparam int FLAG_CAP_BIT    = 5;
    localparam int CMP_CAP_SEL_BIT = 2;
    // Reset values and fixed top values
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [15:0] TOP_8BIT  = 16'h00FF;
    localparam logic [15:0] TOP_9BIT  = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] TOP_MAX   = 16'hFFFF;
    // Noise filter sample count
    localparam int NF_SAMPLES = 4;
    // Counting sequence classes derived from the waveform mode field
    typedef enum logic [1:0] {
        TCU_SEQ_UP_WRAP  = 2'b00,
        TCU_SEQ_UP_CLEAR = 2'b01,
        TCU_SEQ_UPDOWN   = 2'b11
    } tcu_seq_t;
    // Timer tick source selection: stop and external pin edges; other codes take the prescaler tick
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // AHB bus request carried as one packed group
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } tcu_req_t;
endpackage
`default_nettype wire

// ### hdl/tcu_timer.sv
// Timer counter and input capture unit with an AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
module tcu_timer
    import tcu_pkg::*;
(
    // Clock and reset
    input  wire  logic        hclk,
    input  wire  logic        hresetn,
    // AHB-Lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output var   logic [31:0] hrdata,
    output var   logic        hreadyout,
    output var   logic        hresp,
    // Timer inputs
    input  wire  logic        prescale_tick,
    input  wire  logic        external_clock_pin,
    input  wire  logic        capture_input_pin,
    input  wire  logic        comparator_output,
    input  wire  logic        irq_ack_cap,
    // Timer outputs
    output var   logic        overflow_irq,
    output var   logic        capture_irq,
    output var   logic        top_out,
    output var   logic        bottom_out
);
    // Register state
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [7:0]  irq_en_r;
    logic [7:0]  cmp_ctrl_r;
    logic [7:0]  hold_r;
    logic [15:0] counter_value_r;
    logic [15:0] capture_value_r;
    logic        overflow_flag_r;
    logic        capture_flag_r;
    logic        dir_down_r;
    tcu_req_t    req_r;

    // Bus address phase capture
    logic        acc;
    logic        wr_cnt_lo;
    logic        rd_cnt_lo;
    logic        wr_cap_lo;
    logic        rd_cap_lo;
    logic        wr_en;
    logic [7:0]  wdat;
    assign acc  = hsel && hready && htrans[1];
    assign wr_en = req_r.valid && req_r.write;
    assign wdat = hwdata[7:0];
    assign wr_cnt_lo = wr_en && (req_r.addr == ADDR_CNT_LO);
    assign wr_cap_lo = wr_en && (req_r.addr == ADDR_CAP_LO);
    assign rd_cnt_lo = acc && !hwrite && (haddr[7:0] == ADDR_CNT_LO);
    assign rd_cap_lo = acc && !hwrite && (haddr[7:0] == ADDR_CAP_LO);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else if (hready) begin
            req_r.valid <= acc;
            req_r.write <= hwrite;
            req_r.addr  <= {haddr[7:2], 2'b00};
        end
    end

    // Mode decode
    logic [3:0] waveform_mode_field;
    logic [2:0] clock_source_select;
    logic       cap_is_top;
    logic [15:0] top_val;
    tcu_seq_t   seq;
    assign waveform_mode_field = {ctrl_b_r[CTRL_B_WGM_LSB+1 -: 2],
                                  ctrl_a_r[CTRL_A_WGM_LSB+1 -: 2]};
    assign clock_source_select = ctrl_b_r[CTRL_B_CS_LSB+2 -: 3];

    always_comb begin
        seq        = TCU_SEQ_UP_WRAP;
        top_val    = TOP_MAX;
        cap_is_top = 1'b0;
        case (waveform_mode_field)
            4'h1, 4'h5: begin
                top_val = TOP_8BIT;
                seq = (waveform_mode_field == 4'h1) ? TCU_SEQ_UPDOWN : TCU_SEQ_UP_CLEAR;
            end
            4'h2, 4'h6: begin
                top_val = TOP_9BIT;
                seq = (waveform_mode_field == 4'h2) ? TCU_SEQ_UPDOWN : TCU_SEQ_UP_CLEAR;
            end
            4'h3, 4'h7: begin
                top_val = TOP_10BIT;
                seq = (waveform_mode_field == 4'h3) ? TCU_SEQ_UPDOWN : TCU_SEQ_UP_CLEAR;
            end
            4'h8, 4'hA: begin
                top_val = capture_value_r;
                cap_is_top = 1'b1;
                seq = TCU_SEQ_UPDOWN;
            end
            4'hC, 4'hE: begin
                top_val = capture_value_r;
                cap_is_top = 1'b1;
                seq = TCU_SEQ_UP_CLEAR;
            end
            default: begin
                top_val = TOP_MAX;
                seq = TCU_SEQ_UP_WRAP;
            end
        endcase
    end

    // External clock pin synchroniser and edge detect
    logic [2:0] ext_sync_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sync_r <= 3'h0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], external_clock_pin};
        end
    end

    // Timer tick selection
    logic timer_tick;
    always_comb begin
        case (clock_source_select)
            CS_STOP:     timer_tick = 1'b0;
            CS_EXT_FALL: timer_tick = ext_sync_r[2] && !ext_sync_r[1];
            CS_EXT_RISE: timer_tick = !ext_sync_r[2] && ext_sync_r[1];
            default:     timer_tick = prescale_tick;
        endcase
    end

    // Top and bottom indications
    logic at_top;
    logic at_bottom;
    assign at_top    = (counter_value_r == top_val);
    assign at_bottom = (counter_value_r == CNT_RST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_out    <= 1'b0;
            bottom_out <= 1'b0;
        end else begin
            top_out    <= at_top;
            bottom_out <= at_bottom;
        end
    end

    // Counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_value_r <= CNT_RST;
        end else if (wr_cnt_lo) begin
            counter_value_r <= {hold_r, wdat};
        end else if (timer_tick) begin
            case (seq)
                TCU_SEQ_UP_CLEAR:
                    counter_value_r <= at_top ? CNT_RST : counter_value_r + 16'h0001;
                TCU_SEQ_UPDOWN: begin
                    if ((dir_down_r && !at_bottom) || (!dir_down_r && at_top))
                        counter_value_r <= counter_value_r - 16'h0001;
                    else
                        counter_value_r <= counter_value_r + 16'h0001;
                end
                default:
                    counter_value_r <= counter_value_r + 16'h0001;
            endcase
        end
    end

    // Direction of dual-slope sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_down_r <= 1'b0;
        end else if (seq != TCU_SEQ_UPDOWN) begin
            dir_down_r <= 1'b0;
        end else if (timer_tick && !wr_cnt_lo) begin
            if (at_top)
                dir_down_r <= 1'b1;
            else if (at_bottom)
                dir_down_r <= 1'b0;
        end
    end

    // Overflow event per sequence class
    logic ovf_evt;
    always_comb begin
        case (seq)
            TCU_SEQ_UPDOWN: ovf_evt = timer_tick && !wr_cnt_lo && at_bottom && dir_down_r;
            default:        ovf_evt = timer_tick && !wr_cnt_lo && at_top;
        endcase
    end

    // Capture source select and synchroniser
    logic       cap_src;
    logic [1:0] cap_sync_r;
    assign cap_src = cmp_ctrl_r[CMP_CAP_SEL_BIT] ? comparator_output
                                                 : capture_input_pin;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_sync_r <= 2'b00;
        end else begin
            cap_sync_r <= {cap_sync_r[0], cap_src};
        end
    end

    // Noise filter on the system clock
    logic [NF_SAMPLES-2:0] nf_shift_r;
    logic [NF_SAMPLES-1:0] nf_win;
    logic                  nf_out_r;
    logic                  filt;
    // Three stored samples plus the current one keep the added delay at four
    assign nf_win = {nf_shift_r, cap_sync_r[1]};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nf_shift_r <= '0;
            nf_out_r   <= 1'b0;
        end else begin
            nf_shift_r <= nf_win[NF_SAMPLES-2:0];
            if (&nf_win)
                nf_out_r <= 1'b1;
            else if (~|nf_win)
                nf_out_r <= 1'b0;
        end
    end
    assign filt = ctrl_b_r[CTRL_B_NF_BIT] ? nf_out_r : cap_sync_r[1];

    // Edge detector
    logic edge_prev_r;
    logic cap_evt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_prev_r <= 1'b0;
        end else begin
            edge_prev_r <= filt;
        end
    end
    assign cap_evt = !cap_is_top && (ctrl_b_r[CTRL_B_EDGE_BIT] ? (filt && !edge_prev_r)
                                                : (!filt && edge_prev_r));

    // Capture register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_value_r <= CNT_RST;
        end else if (cap_evt) begin
            capture_value_r <= counter_value_r;
        end else if (wr_cap_lo && cap_is_top) begin
            capture_value_r <= {hold_r, wdat};
        end
    end

    // Flags: set wins over clear
    logic wr_flags;
    assign wr_flags = wr_en && (req_r.addr == ADDR_FLAGS);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_flag_r <= 1'b0;
        end else if (cap_evt) begin
            capture_flag_r <= 1'b1;
        end else if (irq_ack_cap || (wr_flags && wdat[FLAG_CAP_BIT])) begin
            capture_flag_r <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag_r <= 1'b0;
        end else if (ovf_evt) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_flags && wdat[FLAG_OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_irq <= 1'b0;
            capture_irq  <= 1'b0;
        end else begin
            overflow_irq <= overflow_flag_r && irq_en_r[FLAG_OVF_BIT];
            capture_irq  <= capture_flag_r && irq_en_r[FLAG_CAP_BIT];
        end
    end

    // Shared holding register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= CTRL_RST;
        end else if (rd_cnt_lo) begin
            hold_r <= counter_value_r[15:8];
        end else if (rd_cap_lo) begin
            hold_r <= capture_value_r[15:8];
        end else if (wr_en && (req_r.addr == ADDR_CNT_HI || req_r.addr == ADDR_CAP_HI)) begin
            hold_r <= wdat;
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_a_r   <= CTRL_RST;
            ctrl_b_r   <= CTRL_RST;
            irq_en_r   <= CTRL_RST;
            cmp_ctrl_r <= CTRL_RST;
        end else if (wr_en) begin
            case (req_r.addr)
                ADDR_CTRL_A:   ctrl_a_r   <= wdat;
                ADDR_CTRL_B:   ctrl_b_r   <= wdat;
                ADDR_IRQ_EN:   irq_en_r   <= wdat;
                ADDR_CMP_CTRL: cmp_ctrl_r <= wdat;
                default:       ;
            endcase
        end
    end

    // Read data, registered at the address phase
    logic [7:0] rsel;
    always_comb begin
        case (haddr[7:0])
            ADDR_CTRL_A:   rsel = ctrl_a_r;
            ADDR_CTRL_B:   rsel = ctrl_b_r;
            ADDR_CNT_LO:   rsel = counter_value_r[7:0];
            ADDR_CNT_HI:   rsel = hold_r;
            ADDR_CAP_LO:   rsel = capture_value_r[7:0];
            ADDR_CAP_HI:   rsel = hold_r;
            ADDR_FLAGS:    rsel = {2'b00, capture_flag_r, 4'h0, overflow_flag_r};
            ADDR_IRQ_EN:   rsel = irq_en_r;
            ADDR_CMP_CTRL: rsel = cmp_ctrl_r;
            ADDR_STATUS:   rsel = {5'h00, dir_down_r, at_top, at_bottom};
            default:       rsel = 8'h00;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (acc && !hwrite) begin
            hrdata <= {24'h000000, rsel};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Assertions
    AST_STOP_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
        (clock_source_select == CS_STOP && !wr_cnt_lo) |=> $stable(counter_value_r))
        else $error("counter moved while stopped");
    AST_WRITE_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cnt_lo |=> counter_value_r == {$past(hold_r), $past(wdat)})
        else $error("counter write lost");
    AST_CAP_COPY: assert property (@(posedge hclk) disable iff (!hresetn)
        cap_evt |=> capture_value_r == $past(counter_value_r) && capture_flag_r)
        else $error("capture copy or flag wrong");
    AST_CAP_FLAG_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(capture_flag_r) |-> $past(cap_evt))
        else $error("capture flag without event");
    AST_CAP_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_ack_cap && !cap_evt) |=> !capture_flag_r)
        else $error("capture flag not cleared");
    AST_HOLD_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_cnt_lo |=> hold_r == $past(counter_value_r[15:8]))
        else $error("holding register not loaded");
    AST_CAP_TOP_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (cap_is_top && !wr_cap_lo) |=> $stable(capture_value_r) && !$rose(capture_flag_r))
        else $error("capture in capture-top mode");
    AST_TICK_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        (timer_tick && !wr_cnt_lo && seq == TCU_SEQ_UP_WRAP) |=>
        counter_value_r == $past(counter_value_r) + 16'h0001)
        else $error("counter did not step");
    AST_FILTER_STEADY: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(nf_out_r) |-> $past(nf_win) == {NF_SAMPLES{nf_out_r}})
        else $error("filter changed early");
    COV_CAPTURE: cover property (@(posedge hclk) disable iff (!hresetn) cap_evt);
    COV_OVERFLOW: cover property (@(posedge hclk) disable iff (!hresetn) ovf_evt);
    COV_WRITE_TICK: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_cnt_lo && timer_tick);
endmodule
`default_nettype wire

// ### sim/tcu_cap_source.sv
// Model of the external capture sources: capture pin and comparator output
`default_nettype none
module tcu_cap_source (
    // Clock
    input  wire logic hclk,
    // Capture sources
    output var  logic capture_input_pin,
    output var  logic comparator_output
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        capture_input_pin = 1'h0;
        comparator_output = 1'h0;
    end
    // Level change launched just after a clock edge
    task automatic set_level(input logic cmp, input logic lvl);
        @(posedge hclk);
        if (cmp) begin
            comparator_output <= lvl;
        end else begin
            capture_input_pin <= lvl;
        end
    endtask
    // High pulse of n cycles on the capture pin
    task automatic glitch(input int n);
        set_level(1'h0, 1'h1);
        repeat (n - 1) @(posedge hclk);
        set_level(1'h0, 1'h0);
    endtask
endmodule
`default_nettype wire

// ### sim/tcu_timer_tb_top.sv
// Testbench of the timer counter and input capture block
`default_nettype none
module tcu_timer_tb_top
    import tcu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        prescale_tick;
    logic        external_clock_pin;
    logic        capture_input_pin;
    logic        comparator_output;
    logic        irq_ack_cap;
    logic        overflow_irq;
    logic        capture_irq;
    logic        top_out;
    logic        bottom_out;
    logic        rd_pend_r;
    logic [7:0]  exp_q[$];
    logic [31:0] lfsr_s;
    logic [15:0] val;
    int          err_count;
    int          check_count;
    int          cycle_count;

    tcu_timer tcu_timer_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .prescale_tick(prescale_tick), .external_clock_pin(external_clock_pin),
        .capture_input_pin(capture_input_pin), .comparator_output(comparator_output),
        .irq_ack_cap(irq_ack_cap), .overflow_irq(overflow_irq), .capture_irq(capture_irq),
        .top_out(top_out), .bottom_out(bottom_out)
    );
    tcu_cap_source tcu_cap_source_inst (
        .hclk(hclk), .capture_input_pin(capture_input_pin),
        .comparator_output(comparator_output)
    );

    initial begin
        hclk = 1'h0;
        forever #10 hclk = ~hclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pin levels {overflow_irq, capture_irq, top_out, bottom_out}, sampled mid-cycle
    task automatic check_pins(input logic [3:0] exp);
        logic [3:0] got;
        @(negedge hclk);
        got = {overflow_irq, capture_irq, top_out, bottom_out};
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
        @(posedge hclk);
    endtask

    // One single transfer: address phase, then data phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'h1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(exp);
        bus(a, 1'h0, 8'h00);
    endtask
    // High byte first on writes, low byte first on reads
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr(lo + 8'h04, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [7:0] lo, input logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 8'h04, v[15:8]);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            prescale_tick <= 1'h1;
            @(posedge hclk);
            prescale_tick <= 1'h0;
            @(posedge hclk);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Read data checker: oldest expectation against each data phase
    always @(posedge hclk) begin
        if (rd_pend_r && hreadyout === 1'h1) begin
            cmp_byte(hrdata[7:0], exp_q.pop_front());
            cmp_byte({7'h00, hresp}, 8'h00);
        end
        rd_pend_r <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
    end

    always @(posedge hclk) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 4000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        hresetn = 1'h0;
        {hsel, hwrite, prescale_tick, external_clock_pin, irq_ack_cap, rd_pend_r} = 6'h00;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        htrans = 2'h0;
        hsize = 3'h2;
        err_count = 0;
        check_count = 0;
        cycle_count = 0;
        lfsr_s = 32'hC50FF7F4;
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        rd(ADDR_CTRL_B, 8'h00);
        rd(ADDR_STATUS, 8'h01);
        wr(8'h2C, 8'hFF);
        rd(8'h2C, 8'h00);
        for (int i = 0; i < 4; i++) begin
            lfsr_s = lfsr_next(lfsr_s);
            val = lfsr_s[15:0];
            wr16(ADDR_CNT_LO, val);
            ticks(2);
            rd16(ADDR_CNT_LO, val);
        end
        wr(ADDR_CNT_HI, 8'hAB);
        rd(ADDR_CAP_LO, 8'h00);
        wr(ADDR_CNT_LO, 8'h11);
        rd16(ADDR_CNT_LO, 16'h0011);
        lfsr_s = lfsr_next(lfsr_s);
        wr16(ADDR_CNT_LO, 16'h1000);
        wr(ADDR_CTRL_B, 8'h01);
        ticks(int'(lfsr_s[2:0]) + 1);
        wr(ADDR_CTRL_B, 8'h00);
        rd16(ADDR_CNT_LO, 16'h1001 + {13'h0000, lfsr_s[2:0]});
        // External pin counted on falling, then on rising edges
        for (int m = 6; m < 8; m++) begin
            wr16(ADDR_CNT_LO, 16'h0100);
            wr(ADDR_CTRL_B, 8'(m));
            repeat (3) begin
                external_clock_pin <= 1'h1;
                wait_cyc(3);
                external_clock_pin <= 1'h0;
                wait_cyc(3);
            end
            wr(ADDR_CTRL_B, 8'h00);
            rd16(ADDR_CNT_LO, 16'h0103);
        end
        wr(ADDR_CTRL_B, 8'h01);
        wr(ADDR_CNT_HI, 8'h22);
        prescale_tick <= 1'h1;
        wr(ADDR_CNT_LO, 8'h33);
        prescale_tick <= 1'h0;
        wr(ADDR_CTRL_B, 8'h00);
        rd16(ADDR_CNT_LO, 16'h2233);
        wr(ADDR_IRQ_EN, 8'h01);
        wr16(ADDR_CNT_LO, 16'hFFFE);
        wr(ADDR_CTRL_B, 8'h01);
        ticks(1);
        rd(ADDR_STATUS, 8'h02);
        ticks(1);
        check_pins(4'h9);
        wr(ADDR_CTRL_B, 8'h00);
        rd(ADDR_FLAGS, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL_A, 8'h01);
        wr16(ADDR_CNT_LO, 16'h00FE);
        wr(ADDR_CTRL_B, 8'h01);
        ticks(2);
        wr(ADDR_CTRL_B, 8'h00);
        rd16(ADDR_CNT_LO, 16'h00FE);
        rd(ADDR_STATUS, 8'h04);
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_IRQ_EN, 8'h20);
        wr16(ADDR_CNT_LO, 16'h1234);
        wr(ADDR_CTRL_B, 8'h40);
        tcu_cap_source_inst.set_level(1'h0, 1'h1);
        wait_cyc(6);
        check_pins(4'h4);
        rd(ADDR_FLAGS, 8'h20);
        rd16(ADDR_CAP_LO, 16'h1234);
        irq_ack_cap <= 1'h1;
        @(posedge hclk);
        irq_ack_cap <= 1'h0;
        @(posedge hclk);
        check_pins(4'h0);
        tcu_cap_source_inst.set_level(1'h0, 1'h0);
        wait_cyc(6);
        rd(ADDR_FLAGS, 8'h00);
        wr16(ADDR_CNT_LO, 16'h5678);
        wr(ADDR_CTRL_B, 8'h00);
        tcu_cap_source_inst.set_level(1'h0, 1'h1);
        wait_cyc(6);
        rd(ADDR_FLAGS, 8'h00);
        tcu_cap_source_inst.set_level(1'h0, 1'h0);
        wait_cyc(6);
        rd(ADDR_FLAGS, 8'h20);
        rd16(ADDR_CAP_LO, 16'h5678);
        wr(ADDR_FLAGS, 8'h20);
        rd(ADDR_FLAGS, 8'h00);
        wr16(ADDR_CNT_LO, 16'h0ABC);
        wr(ADDR_CTRL_B, 8'hC0);
        tcu_cap_source_inst.glitch(3);
        wait_cyc(12);
        rd(ADDR_FLAGS, 8'h00);
        tcu_cap_source_inst.set_level(1'h0, 1'h1);
        wait_cyc(12);
        rd(ADDR_FLAGS, 8'h20);
        rd16(ADDR_CAP_LO, 16'h0ABC);
        wr(ADDR_CTRL_B, 8'h40);
        wr(ADDR_CMP_CTRL, 8'h04);
        wr(ADDR_FLAGS, 8'h20);
        wr16(ADDR_CNT_LO, 16'h0F0F);
        tcu_cap_source_inst.set_level(1'h1, 1'h1);
        wait_cyc(6);
        rd(ADDR_FLAGS, 8'h20);
        rd16(ADDR_CAP_LO, 16'h0F0F);
        wr(ADDR_CMP_CTRL, 8'h00);
        wr(ADDR_FLAGS, 8'h20);
        wr(ADDR_CTRL_B, 8'h18);
        wr16(ADDR_CAP_LO, 16'h55AA);
        rd16(ADDR_CAP_LO, 16'h55AA);
        tcu_cap_source_inst.set_level(1'h0, 1'h0);
        wait_cyc(6);
        rd(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL_B, 8'h00);
        wr16(ADDR_CAP_LO, 16'h1111);
        rd16(ADDR_CAP_LO, 16'h55AA);
        wait_cyc(3);
        give_verdict();
    end
endmodule
`default_nettype wire
